// ===== rtl/sfl_flash_host.sv
// Host end: frames write enable, the write command and the status polling.
`timescale 1ns/1ns
`include "sfl_map.svh"
module sfl_flash_host (
   input  wire logic              i_clk_sys,   // System clock, 50 MHz.
   input  wire logic              i_reset_n,   // Synchronous reset, active low.
   sfl_link_if.host               link,        // Serial link pins.
   input  wire logic              i_cmd_valid, // Request a command.
   input  wire sfl_pkg::sfl_cmd_type i_cmd,    // Which command.
   input  wire logic [23:0]       i_addr,      // Target address.
   input  wire logic [8:0]        i_len,       // Page data bytes, 1 to 256.
   input  wire logic [7:0]        i_data,      // Next data byte.
   output logic                   o_cmd_ready, // Ready for a command.
   output logic                   o_data_take, // Pulse: i_data was taken.
   output logic                   o_done,      // Pulse: command finished.
   output logic [7:0]             o_status     // Last status byte read.
);

   // -------------------------------------------------------------------------
   // Data input synchroniser.
   // -------------------------------------------------------------------------
   logic [2:0] so_p;
   logic       so_s;

   // Three flip-flops; the level moves once stages two and three agree.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         so_p <= 3'h7;
         so_s <= 1'b1;
      end else begin
         so_p <= {so_p[1:0], link.so_line};
         if (so_p[1] == so_p[2]) begin
            so_s <= so_p[2];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Frame engine.
   // -------------------------------------------------------------------------
   logic        go;
   logic [7:0]  f_op;
   logic [8:0]  f_len;
   logic [23:0] addr;
   logic        f_run;
   logic        f_end;
   logic        f_gap;
   logic        f_done;
   logic [4:0]  ph;
   logic [2:0]  bit_i;
   logic [8:0]  byte_i;
   logic [7:0]  tx_sh;
   logic [7:0]  rx_sh;
   logic        cs_n;
   logic        sck;
   logic        si;
   logic        tick;
   logic [8:0]  nxt_i;
   logic [7:0]  nxt_b;
   logic        nxt_data;

   assign tick      = (ph == `SFL_SCK_HALF - 5'h01);
   assign nxt_i     = byte_i + 9'h001;
   assign link.cs_n = cs_n;
   assign link.sck  = sck;
   assign link.si   = si;

   // Chooses the byte that follows in the frame and whether it is user data.
   always_comb begin
      nxt_data = 1'b0;
      nxt_b    = i_data;
      if (f_op == `SFL_OP_WRSR) begin
         nxt_data = 1'b1;
      end else if (f_op == `SFL_OP_RDSR) begin
         nxt_b = 8'h00;
      end else if (nxt_i == 9'h001) begin
         nxt_b = addr[23:16];
      end else if (nxt_i == 9'h002) begin
         nxt_b = addr[15:8];
      end else if (nxt_i == 9'h003) begin
         nxt_b = addr[7:0];
      end else begin
         nxt_data = 1'b1;                                          // [R02]
      end
   end

   // Generates the serial clock by division, shifts bytes out and in.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         f_run <= 1'b0;
         f_end <= 1'b0;
         f_gap <= 1'b0;
         f_done <= 1'b0;
         ph    <= 5'h00;
         bit_i <= 3'h0;
         byte_i <= 9'h000;
         tx_sh <= 8'h00;
         rx_sh <= 8'h00;
         cs_n  <= 1'b1;
         sck   <= 1'b0;
         si    <= 1'b0;
         o_data_take <= 1'b0;
      end else begin
         f_done      <= 1'b0;
         o_data_take <= 1'b0;
         ph <= (f_run | f_end | f_gap) & ~tick ? ph + 5'h01 : 5'h00;
         if (go) begin
            cs_n   <= 1'b0;
            f_run  <= 1'b1;
            bit_i  <= 3'h0;
            byte_i <= 9'h000;
            tx_sh  <= f_op;
            si     <= f_op[7];
         end else if (f_run & tick) begin
            if (!sck) begin
               sck <= 1'b1;
            end else begin
               sck   <= 1'b0;
               rx_sh <= {rx_sh[6:0], so_s};
               bit_i <= bit_i + 3'h1;
               if (bit_i != 3'h7) begin
                  tx_sh <= {tx_sh[6:0], 1'b0};
                  si    <= tx_sh[6];
               end else if (nxt_i == f_len) begin
                  f_run <= 1'b0;
                  f_end <= 1'b1;
               end else begin
                  byte_i      <= nxt_i;
                  tx_sh       <= nxt_b;
                  si          <= nxt_b[7];
                  o_data_take <= nxt_data;
               end
            end
         end else if (f_end & tick) begin
            cs_n  <= 1'b1;                                         // [R02] [R04]
            f_end <= 1'b0;
            f_gap <= 1'b1;
         end else if (f_gap & tick) begin
            f_gap  <= 1'b0;
            f_done <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Command sequencer.
   // -------------------------------------------------------------------------
   sfl_pkg::sfl_host_state_type state;
   sfl_pkg::sfl_cmd_type        cmd;

   // Writes: enable frame, command frame, then status frames until not busy; a status read is one status frame.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         state       <= sfl_pkg::SFL_H_IDLE;
         cmd         <= sfl_pkg::SFL_CMD_READ_SR;
         go          <= 1'b0;
         f_op        <= 8'h00;
         f_len       <= 9'h000;
         addr        <= 24'h00_0000;
         o_cmd_ready <= 1'b1;
         o_done      <= 1'b0;
         o_status    <= 8'h00;
      end else begin
         go     <= 1'b0;
         o_done <= 1'b0;
         case (state)
            sfl_pkg::SFL_H_IDLE: begin
               if (i_cmd_valid & o_cmd_ready) begin
                  o_cmd_ready <= 1'b0;
                  cmd  <= i_cmd;
                  addr <= i_addr;
                  go   <= 1'b1;
                  if (i_cmd == sfl_pkg::SFL_CMD_READ_SR) begin
                     f_op  <= `SFL_OP_RDSR;
                     f_len <= 9'h002;
                     state <= sfl_pkg::SFL_H_POLL;
                  end else begin
                     f_op  <= `SFL_OP_WREN;                        // [R01]
                     f_len <= 9'h001;
                     state <= sfl_pkg::SFL_H_WREN;
                  end
               end
            end
            sfl_pkg::SFL_H_WREN: begin
               if (f_done) begin
                  go    <= 1'b1;
                  state <= sfl_pkg::SFL_H_CMD;
                  case (cmd)
                     sfl_pkg::SFL_CMD_PAGE_PROG: begin
                        f_op  <= `SFL_OP_PP;                       // [R02]
                        f_len <= 9'h004 + ((i_len == 9'h000) | (i_len > `SFL_MAX_PAGE)
                                 ? 9'h001 : i_len);
                     end
                     sfl_pkg::SFL_CMD_SMALL_ERASE: begin
                        f_op  <= `SFL_OP_SSE;
                        f_len <= 9'h004;
                     end
                     sfl_pkg::SFL_CMD_SECT_ERASE: begin
                        f_op  <= `SFL_OP_SE;
                        f_len <= 9'h004;
                     end
                     sfl_pkg::SFL_CMD_CHIP_ERASE: begin
                        f_op  <= `SFL_OP_CE;                       // [R03]
                        f_len <= 9'h001;
                     end
                     default: begin
                        f_op  <= `SFL_OP_WRSR;
                        f_len <= 9'h002;
                     end
                  endcase
               end
            end
            sfl_pkg::SFL_H_CMD: begin
               if (f_done) begin
                  go    <= 1'b1;
                  f_op  <= `SFL_OP_RDSR;
                  f_len <= 9'h002;
                  state <= sfl_pkg::SFL_H_POLL;
               end
            end
            sfl_pkg::SFL_H_POLL: begin
               if (f_done) begin
                  o_status <= rx_sh;
                  if (rx_sh[`SFL_SR_BUSY] & (cmd != sfl_pkg::SFL_CMD_READ_SR)) begin
                     go <= 1'b1;                                   // [R05]
                  end else begin
                     o_done      <= 1'b1;
                     o_cmd_ready <= 1'b1;
                     state       <= sfl_pkg::SFL_H_IDLE;
                  end
               end
            end
            default: begin
               state <= sfl_pkg::SFL_H_IDLE;
            end
         endcase
      end
   end

endmodule // sfl_flash_host

// ===== rtl/sfl_map.svh
// Constants for the serial flash program, erase and status-write flow.
//
// Notes on behaviour
// R01 - Host sends write enable as its own frame.
// R02 - Program: opcode, three address, data; start on rise.
// R03 - Chip erase is the opcode alone, after enable.
// R04 - Erase starts on chip select rise ending command.
// R05 - Host polls status until bit 0 is zero.
// R06 - Program or erase end clears write enable.
// R07 - Status write end returns to write disabled.
// R08 - Status write finishes within 15 ms, busy meanwhile.
// R09 - Page program finishes within 5.0 ms.
// R10 - Small sector erase finishes within 0.15 s.
// R11 - Sector erase finishes within 0.25 s.
// R12 - Chip erase finishes within 1.6 s.
// R13 - Write command ending mid-byte is ignored.
// R14 - Page program with partial data byte is rejected.
// R15 - While busy, status bit 0 high, writes refused.
`ifndef SFL_MAP_SVH
`define SFL_MAP_SVH

// ----------------------------------------------------------------------------
// Command opcodes.
// ----------------------------------------------------------------------------
`define SFL_OP_WREN   8'h06
`define SFL_OP_WRDI   8'h04
`define SFL_OP_RDSR   8'h05
`define SFL_OP_WRSR   8'h01
`define SFL_OP_PP     8'h02
`define SFL_OP_SSE    8'h20
`define SFL_OP_SE     8'hD8
`define SFL_OP_CE     8'hC7

// ----------------------------------------------------------------------------
// Status byte layout and frame lengths in bytes.
// ----------------------------------------------------------------------------
`define SFL_SR_BUSY     0
`define SFL_SR_WEL      1
`define SFL_SR_RESET    8'h00
`define SFL_ADDR_BYTES  4'h4
`define SFL_MAX_PAGE    9'h100

// ----------------------------------------------------------------------------
// Timing: figures in their own unit, then clock cycles at 50 MHz.
// ----------------------------------------------------------------------------
`define SFL_CLK_HZ      50000000
`define SFL_T_SRW_MS    5
`define SFL_T_SRW_MAX_MS 15
`define SFL_T_PP_MS     4.0
`define SFL_T_PP_MAX_MS 5.0
`define SFL_T_SSE_S     0.04
`define SFL_T_SSE_MAX_S 0.15
`define SFL_T_SE_S      0.08
`define SFL_T_SE_MAX_S  0.25
`define SFL_T_CHE_S     0.25
`define SFL_T_CHE_MAX_S 1.6
`define SFL_CYC_SRW     (`SFL_T_SRW_MS * (`SFL_CLK_HZ / 1000))
`define SFL_CYC_SRW_MAX (`SFL_T_SRW_MAX_MS * (`SFL_CLK_HZ / 1000))
`define SFL_CYC_PP      (int'(`SFL_T_PP_MS * (`SFL_CLK_HZ / 1000)))
`define SFL_CYC_PP_MAX  (int'(`SFL_T_PP_MAX_MS * (`SFL_CLK_HZ / 1000)))
`define SFL_CYC_SSE     (int'(`SFL_T_SSE_S * `SFL_CLK_HZ))
`define SFL_CYC_SSE_MAX (int'(`SFL_T_SSE_MAX_S * `SFL_CLK_HZ))
`define SFL_CYC_SE      (int'(`SFL_T_SE_S * `SFL_CLK_HZ))
`define SFL_CYC_SE_MAX  (int'(`SFL_T_SE_MAX_S * `SFL_CLK_HZ))
`define SFL_CYC_CHE     (int'(`SFL_T_CHE_S * `SFL_CLK_HZ))
`define SFL_CYC_CHE_MAX (int'(`SFL_T_CHE_MAX_S * `SFL_CLK_HZ))
// Host serial clock half period in system cycles.
`define SFL_SCK_HALF    5'h08

`endif

// ===== rtl/sfl_pkg.sv
// Types used by the host end of the serial flash link.
package sfl_pkg;

   // Operations a user may ask of the host end.
   typedef enum logic [2:0] {
      SFL_CMD_PAGE_PROG  = 3'b000,
      SFL_CMD_SMALL_ERASE = 3'b001,
      SFL_CMD_SECT_ERASE = 3'b010,
      SFL_CMD_CHIP_ERASE = 3'b011,
      SFL_CMD_WRITE_SR   = 3'b100,
      SFL_CMD_READ_SR    = 3'b101
   } sfl_cmd_type;

   // Host sequencing states.
   typedef enum logic [1:0] {
      SFL_H_IDLE = 2'b00,
      SFL_H_WREN = 2'b01,
      SFL_H_CMD  = 2'b10,
      SFL_H_POLL = 2'b11
   } sfl_host_state_type;

endpackage

// ===== rtl/sfl_link_if.sv
// Four-wire serial link between the host end and the flash end.
`timescale 1ns/1ns
interface sfl_link_if;
   logic cs_n;      // Chip select, low during a frame.
   logic sck;       // Serial clock made by the host.
   logic si;        // Serial data into the flash.
   logic so;        // Serial data out of the flash.
   logic so_oe_n;   // Output enable of so, low while the flash drives it.
   logic so_line;   // Resolved so wire, pulled high when undriven.

   // The so wire floats high when the flash releases it.
   assign so_line = so_oe_n ? 1'b1 : so;

   modport dev  (input cs_n, input sck, input si, output so, output so_oe_n);
   modport host (output cs_n, output sck, output si, input so_line);
endinterface

// ===== rtl/sfl_flash_dev.sv
// Flash end: command decode, write enable latch, busy timing, status read.
`timescale 1ns/1ns
`include "sfl_map.svh"
module sfl_flash_dev #(
   parameter int unsigned P_CYC_SRW = `SFL_CYC_SRW,
   parameter int unsigned P_CYC_PP  = `SFL_CYC_PP,
   parameter int unsigned P_CYC_SSE = `SFL_CYC_SSE,
   parameter int unsigned P_CYC_SE  = `SFL_CYC_SE,
   parameter int unsigned P_CYC_CHE = `SFL_CYC_CHE
) (
   input  wire logic        i_clk_sys,   // System clock, 50 MHz.
   input  wire logic        i_reset_n,   // Synchronous reset, active low.
   sfl_link_if.dev          link,        // Serial link pins.
   output logic             o_busy,      // Operation in progress.
   output logic             o_wel,       // Write enable latch.
   output logic [7:0]       o_status,    // Full status byte.
   output logic             o_op_start,  // Pulse: operation begins.
   output logic [7:0]       o_op_code,   // Opcode of the running operation.
   output logic [23:0]      o_op_addr,   // Address of the running operation.
   output logic             o_op_done,   // Pulse: operation ends.
   output logic [7:0]       o_wr_data,   // Page data byte received.
   output logic             o_wr_valid   // Pulse: o_wr_data is new.
);

   // -------------------------------------------------------------------------
   // Pin synchronisers.
   // -------------------------------------------------------------------------
   logic [2:0]  sck_p;
   logic [2:0]  cs_p;
   logic [2:0]  si_p;
   logic        sck_lvl;
   logic        cs_lvl;

   // Three flip-flops per pin; clock and chip select levels count once stages two and three agree.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         sck_p <= 3'h0;
         cs_p  <= 3'h7;
         si_p  <= 3'h0;
      end else begin
         sck_p <= {sck_p[1:0], link.sck};
         cs_p  <= {cs_p[1:0], link.cs_n};
         si_p  <= {si_p[1:0], link.si};
      end
   end

   // Settled levels of clock and chip select.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         sck_lvl <= 1'b0;
         cs_lvl  <= 1'b1;
      end else begin
         if (sck_p[1] == sck_p[2]) begin
            sck_lvl <= sck_p[2];
         end
         if (cs_p[1] == cs_p[2]) begin
            cs_lvl <= cs_p[2];
         end
      end
   end

   logic cs_act;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;

   // Edge events derived from agreeing stages against the settled level.
   assign cs_act   = ~cs_lvl;
   assign cs_fall  = (cs_p[1] == cs_p[2]) & ~cs_p[2] & cs_lvl;
   assign cs_rise  = (cs_p[1] == cs_p[2]) & cs_p[2] & ~cs_lvl;
   assign sck_rise = cs_act & (sck_p[1] == sck_p[2]) & sck_p[2] & ~sck_lvl;
   assign sck_fall = cs_act & (sck_p[1] == sck_p[2]) & ~sck_p[2] & sck_lvl;

   // -------------------------------------------------------------------------
   // Frame receiver.
   // -------------------------------------------------------------------------
   logic [2:0]  bit_cnt;
   logic [3:0]  byte_cnt;
   logic [6:0]  sh_in;
   logic [7:0]  opcode;
   logic [23:0] addr;
   logic [7:0]  rx_byte;
   logic        busy;
   logic        wel;
   logic [5:0]  sr_user;

   assign rx_byte = {sh_in, si_p[2]};

   // Shifts bits in on each clock rise and sorts the bytes into fields.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         bit_cnt  <= 3'h0;
         byte_cnt <= 4'h0;
         sh_in    <= 7'h00;
         opcode   <= 8'h00;
         addr     <= 24'h00_0000;
      end else if (cs_fall) begin
         bit_cnt  <= 3'h0;
         byte_cnt <= 4'h0;
      end else if (sck_rise) begin
         sh_in   <= rx_byte[6:0];
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7) begin
            if (byte_cnt == 4'h0) begin
               opcode <= rx_byte;
            end else if (byte_cnt < `SFL_ADDR_BYTES) begin
               addr <= {addr[15:0], rx_byte};
            end
            if (byte_cnt != 4'hF) begin
               byte_cnt <= byte_cnt + 4'h1;
            end
         end
      end
   end

   // Page data bytes are offered to the user as they arrive.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_wr_valid <= 1'b0;
         o_wr_data  <= 8'h00;
      end else begin
         o_wr_valid <= sck_rise & (bit_cnt == 3'h7) & (byte_cnt >= `SFL_ADDR_BYTES)
                       & (opcode == `SFL_OP_PP) & wel & ~busy;
         if (sck_rise & (bit_cnt == 3'h7)) begin
            o_wr_data <= rx_byte;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Command decode at the end of the frame.
   // -------------------------------------------------------------------------
   logic        whole;
   logic        next_start;
   logic [31:0] next_dur;

   // Only frames that end on a byte boundary and find the device idle count.
   assign whole = (bit_cnt == 3'h0) & ~busy;                       // [R13] [R15]

   // Picks the write operation a closing frame requests, if any.
   always_comb begin
      next_start = 1'b0;
      next_dur   = P_CYC_PP;
      if (cs_rise & whole & wel) begin
         case (opcode)
            `SFL_OP_PP: begin
               next_start = (byte_cnt > `SFL_ADDR_BYTES);          // [R02] [R14]
               next_dur   = P_CYC_PP;                              // [R09]
            end
            `SFL_OP_SSE: begin
               next_start = (byte_cnt == `SFL_ADDR_BYTES);         // [R04]
               next_dur   = P_CYC_SSE;                             // [R10]
            end
            `SFL_OP_SE: begin
               next_start = (byte_cnt == `SFL_ADDR_BYTES);         // [R04]
               next_dur   = P_CYC_SE;                              // [R11]
            end
            `SFL_OP_CE: begin
               next_start = (byte_cnt == 4'h1);                    // [R03] [R04]
               next_dur   = P_CYC_CHE;                             // [R12]
            end
            `SFL_OP_WRSR: begin
               next_start = (byte_cnt == 4'h2);
               next_dur   = P_CYC_SRW;                             // [R08]
            end
            default: begin
               next_start = 1'b0;
               next_dur   = P_CYC_PP;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Write enable latch, busy timer and operation reporting.
   // -------------------------------------------------------------------------
   logic [31:0] timer;

   // Runs the internal operation and clears write enable when it ends.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         busy       <= 1'b0;
         wel        <= 1'b0;
         timer      <= 32'h0000_0000;
         sr_user    <= 6'h00;
         o_op_start <= 1'b0;
         o_op_done  <= 1'b0;
         o_op_code  <= 8'h00;
         o_op_addr  <= 24'h00_0000;
      end else begin
         o_op_start <= next_start;
         o_op_done  <= 1'b0;
         if (next_start) begin
            busy      <= 1'b1;                                     // [R15]
            timer     <= next_dur;
            o_op_code <= opcode;
            o_op_addr <= addr;
            if (opcode == `SFL_OP_WRSR) begin
               sr_user <= addr[7:2];
            end
         end else if (busy) begin
            if (timer <= 32'h0000_0001) begin
               busy      <= 1'b0;
               wel       <= 1'b0;                                  // [R06] [R07]
               o_op_done <= 1'b1;
            end else begin
               timer <= timer - 32'h0000_0001;
            end
         end else if (cs_rise & whole & (byte_cnt == 4'h1)) begin
            if (opcode == `SFL_OP_WREN) begin
               wel <= 1'b1;                                        // [R01]
            end else if (opcode == `SFL_OP_WRDI) begin
               wel <= 1'b0;
            end
         end
      end
   end

   // Mirrors the state onto registered user outputs.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_busy   <= 1'b0;
         o_wel    <= 1'b0;
         o_status <= `SFL_SR_RESET;
      end else begin
         o_busy   <= busy;
         o_wel    <= wel;
         o_status <= {sr_user, wel, busy};
      end
   end

   // -------------------------------------------------------------------------
   // Status read output.
   // -------------------------------------------------------------------------
   logic [7:0] status;
   logic       so;
   logic       so_oe_n;

   assign status       = {sr_user, wel, busy};
   assign link.so      = so;
   assign link.so_oe_n = so_oe_n;

   // Drives status bits on each clock fall, repeating for as long as polled.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         so      <= 1'b0;
         so_oe_n <= 1'b1;
      end else if (!cs_act | cs_rise) begin
         so_oe_n <= 1'b1;
      end else if (sck_fall & (opcode == `SFL_OP_RDSR) & (byte_cnt != 4'h0)) begin
         so      <= status[3'h7 - bit_cnt];                        // [R05] [R15]
         so_oe_n <= 1'b0;
      end
   end

endmodule // sfl_flash_dev

// ===== tb/sfl_link_assertions.sv
// Concurrent checks on the serial link and the flash end's status outputs.
`timescale 1ns/1ns
module sfl_link_assertions (
   input wire logic       i_clk_sys,  // System clock.
   input wire logic       i_reset_n,  // Synchronous reset, active low.
   input wire logic       cs_n,       // Chip select.
   input wire logic       sck,        // Serial clock.
   input wire logic       si,         // Data into the flash.
   input wire logic       so_oe_n,    // Flash output enable, low while driving.
   input wire logic       o_busy,     // Flash busy.
   input wire logic       o_wel,      // Write enable latch.
   input wire logic [7:0] o_status,   // Status byte.
   input wire logic       o_op_start, // Operation begins.
   input wire logic       o_op_done   // Operation ends.
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("sck high outside a frame");
   a_si_held_rise: assert property (!cs_n && $rose(sck) |-> $stable(si))
      else $error("si moved at sck rise");
   a_so_released: assert property (cs_n [*5] |-> so_oe_n)
      else $error("so still driven after frame");
   a_start_after_rise: assert property (o_op_start |-> cs_n && $past(cs_n, 3))
      else $error("operation began inside a frame");
   a_start_needs_wel: assert property (o_op_start |-> $past(o_wel) && !$past(o_busy))
      else $error("operation began without enable or while busy");
   a_busy_length: assert property (o_op_start |-> ##[1:2] o_busy ##197 o_busy ##[1:4] !o_busy)
      else $error("busy time wrong");
   a_status_busy: assert property (o_op_start |=> o_status[0])
      else $error("status bit 0 differs from busy");
   a_done_clears: assert property (o_op_done |-> ##[0:1] (!o_busy && !o_wel))
      else $error("enable or busy left set after operation");
endmodule // sfl_link_assertions

// ===== tb/serial_flash_program_erase_flow_tb.sv
// Bench joining the host and flash ends over the serial link.
`timescale 1ns/1ns
`include "sfl_map.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; $display("wrong value %s expected %0h seen %0h", n, e, s); end end
module serial_flash_program_erase_flow_tb;
   logic                 i_clk_sys = 1'b0;
   logic                 i_reset_n = 1'b0;
   logic                 i_cmd_valid = 1'b0;
   sfl_pkg::sfl_cmd_type i_cmd = sfl_pkg::SFL_CMD_READ_SR;
   logic [23:0]          i_addr = 24'h12_3456;
   logic [8:0]           i_len = 9'h001;
   logic [7:0]           i_data = 8'h00;
   wire                  ready, take, done, busy, wel, op_start, op_done, wr_valid;
   wire  [7:0]           h_status, d_status, op_code, wr_data;
   wire  [23:0]          op_addr;
   int                   err_count = 0, n_compared = 0, n_start = 0, n_busy = 0, n_wr = 0;
   sfl_link_if i_sfl_link_if ();
   sfl_flash_dev #(.P_CYC_SRW(200), .P_CYC_PP(200), .P_CYC_SSE(200), .P_CYC_SE(200),
      .P_CYC_CHE(200)) i_sfl_flash_dev (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .link(i_sfl_link_if), .o_busy(busy), .o_wel(wel), .o_status(d_status),
      .o_op_start(op_start), .o_op_code(op_code), .o_op_addr(op_addr), .o_op_done(op_done),
      .o_wr_data(wr_data), .o_wr_valid(wr_valid));
   sfl_flash_host i_sfl_flash_host (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .link(i_sfl_link_if), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_addr(i_addr),
      .i_len(i_len), .i_data(i_data), .o_cmd_ready(ready), .o_data_take(take),
      .o_done(done), .o_status(h_status));
   sfl_link_assertions i_sfl_link_assertions (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .cs_n(i_sfl_link_if.cs_n), .sck(i_sfl_link_if.sck), .si(i_sfl_link_if.si),
      .so_oe_n(i_sfl_link_if.so_oe_n), .o_busy(busy), .o_wel(wel), .o_status(d_status),
      .o_op_start(op_start), .o_op_done(op_done));
   // Free-running system clock at 50 MHz.
   initial forever #10 i_clk_sys = ~i_clk_sys;
   // Counts starts, busy cycles and received page bytes over the run.
   always @(posedge i_clk_sys) begin
      n_start <= n_start + op_start;
      n_busy <= n_busy + busy;
      n_wr <= n_wr + wr_valid;
   end
   // Moves to a fresh page byte once the host has taken the previous one.
   always @(negedge i_clk_sys) if (take === 1'b1) i_data <= i_data + 8'h11;
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Hands one command to the host end and waits a bounded time for its end.
   task automatic run(input sfl_pkg::sfl_cmd_type c, input logic [8:0] n);
      int k;
      @(negedge i_clk_sys);
      i_cmd = c;
      i_len = n;
      i_cmd_valid = 1'b1;
      @(negedge i_clk_sys);
      i_cmd_valid = 1'b0;
      for (k = 0; k < 40000 && done !== 1'b1; k++) @(negedge i_clk_sys);
      if (k == 40000) begin
         err_count++;
         report_and_stop();
      end
   endtask
   // Runs one write command and checks what the flash end did with it.
   task automatic step(input sfl_pkg::sfl_cmd_type c, input logic [7:0] code,
                       input logic [8:0] n);
      int s, b, w;
      s = n_start;
      b = n_busy;
      w = n_wr;
      run(c, n);
      `CHK("starts", 1, n_start - s)
      `CHK("opcode", code, op_code)
      `CHK("busy cycles", 200, n_busy - b)
      `CHK("enable latch", 1'b0, wel)
      `CHK("status bit 0", 1'b0, h_status[0])
      if (c != sfl_pkg::SFL_CMD_WRITE_SR && c != sfl_pkg::SFL_CMD_CHIP_ERASE)
         `CHK("address", i_addr, op_addr)
      if (c == sfl_pkg::SFL_CMD_PAGE_PROG) `CHK("page bytes", int'(n), n_wr - w)
   endtask
   // Main sequence: status read, a full page, every erase, a status write.
   initial begin
      repeat (4) @(negedge i_clk_sys);
      i_reset_n = 1'b1;
      repeat (6) @(negedge i_clk_sys);
      run(sfl_pkg::SFL_CMD_READ_SR, 9'h001);
      `CHK("status after reset", 8'h00, h_status)
      step(sfl_pkg::SFL_CMD_PAGE_PROG, `SFL_OP_PP, 9'h100);
      step(sfl_pkg::SFL_CMD_SMALL_ERASE, `SFL_OP_SSE, 9'h001);
      step(sfl_pkg::SFL_CMD_SECT_ERASE, `SFL_OP_SE, 9'h001);
      step(sfl_pkg::SFL_CMD_CHIP_ERASE, `SFL_OP_CE, 9'h001);
      i_data = 8'hFC;
      step(sfl_pkg::SFL_CMD_WRITE_SR, `SFL_OP_WRSR, 9'h001);
      run(sfl_pkg::SFL_CMD_READ_SR, 9'h001);
      `CHK("status after write", 8'hFC, h_status)
      report_and_stop();
   end
endmodule // serial_flash_program_erase_flow_tb
